// File: pkg/phy_ext_page1_pkg.sv
// Constants, types and field layout for the page-1 management register group.
// Assumes a 250 MHz core clock and a clause-22 style serial management frame.
// Behaviour
// (RULE1) Carrier-extension disable bit, reset one, blocks extension
// (RULE2) Sleep timer code selects one to four seconds
// (RULE3) Wake timer code selects 160/400/800/2000 ms
// (RULE4) Software may flag slow management clock, optional
// (RULE5) Media status reads 00 none, 01 copper
// (RULE6) No-preamble bit lets 10M receive skip preamble
// (RULE7) Downshift enable allows speed drop, else none
// (RULE8) Downshift code sets 2 to 5 failed attempts
// (RULE9) Downshift status reads one when required/done
// (RULE10) Bits 15:11 read management address, writes ignored
// (RULE11) Powered-device status valid only while detection enabled
// (RULE12) Eight-bit CRC error count clears on read
// (RULE13) Software clears force-idle before generator enable
// (RULE14) Generator sends fixed count, or blocks until cleared
// (RULE15) Length code selects 125/64/1518/10000 byte frames
// (RULE16) Gap bit selects 96 ns or 8192 ns
// (RULE17) Destination all ones with programmable low nibble
// (RULE18) Source low nibble from bits 5:2
// (RULE19) Payload type picks random or repeated pattern
// (RULE20) Bit 0 selects corrupted or correct FCS
// (RULE21) Fixed payload repeats the 16-bit pattern register
// (RULE22) Settings change applies only after run restart
// (RULE23) Generator sends only while enable and run set; code finishes the current frame and gap after either clears
package phy_ext_page1_pkg;
   localparam logic [4:0] REG_SLEEP_DS = 5'h14;
   localparam logic [4:0] REG_PD_CRC = 5'h17;
   localparam logic [4:0] REG_GEN_CTL = 5'h1d;
   localparam logic [4:0] REG_GEN_PAT = 5'h1e;
   localparam logic [15:0] SLEEP_DS_RST = 16'ha004;
   localparam logic [15:0] SLEEP_DS_WMASK = 16'hfc3c;
   localparam logic [15:0] GEN_CTL_RST = 16'h0040;
   localparam logic [15:0] GEN_PAT_RST = 16'h0000;
   localparam int CE_DIS_BIT = 15;
   localparam int SLEEP_LSB = 13;
   localparam int WAKE_LSB = 11;
   localparam int SLOW_MDC_BIT = 10;
   localparam int NOPRE_BIT = 5;
   localparam int DS_EN_BIT = 4;
   localparam int DS_CNT_LSB = 2;
   localparam int PD_EN_BIT = 10;
   localparam int GEN_EN_BIT = 15;
   localparam int GEN_RUN_BIT = 14;
   localparam int GEN_DUR_BIT = 13;
   localparam int GEN_LEN_LSB = 11;
   localparam int GEN_IPG_BIT = 10;
   localparam int GEN_DA_LSB = 6;
   localparam int GEN_SA_LSB = 2;
   localparam int GEN_PAY_BIT = 1;
   localparam int GEN_BADFCS_BIT = 0;
   localparam logic [1:0] MEDIA_NONE = 2'h0;
   localparam logic [1:0] MEDIA_COPPER = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam int MDIO_PRE_BITS = 32;
   localparam int CLK_MHZ = 250;
   localparam int MS_NS = 1000000;
   localparam int MS_CYC = MS_NS * CLK_MHZ / 1000;
   localparam int SLEEP_UNIT_MS = 1000;
   localparam logic [11:0] WAKE_MS0 = 12'd160;
   localparam logic [11:0] WAKE_MS1 = 12'd400;
   localparam logic [11:0] WAKE_MS2 = 12'd800;
   localparam logic [11:0] WAKE_MS3 = 12'd2000;
   localparam int IPG_SHORT_NS = 96;
   localparam int IPG_LONG_NS = 8192;
   localparam logic [11:0] IPG_SHORT_CYC = 12'(IPG_SHORT_NS * CLK_MHZ / 1000);
   localparam logic [11:0] IPG_LONG_CYC = 12'(IPG_LONG_NS * CLK_MHZ / 1000);
   localparam logic [13:0] LEN0 = 14'd125;
   localparam logic [13:0] LEN1 = 14'd64;
   localparam logic [13:0] LEN2 = 14'd1518;
   localparam logic [13:0] LEN3 = 14'd10000;
   localparam logic [13:0] HDR_BYTES = 14'd12;
   localparam logic [13:0] FCS_BYTES = 14'd4;
   localparam int PKT_TOTAL_DOC = 30000000;
   localparam int PKT_BLOCK_DOC = 10000;
   localparam logic [31:0] CRC_POLY = 32'hedb88320;
   localparam logic [31:0] CRC_INIT = 32'hffffffff;
   localparam logic [15:0] LFSR_SEED = 16'hace1;
   localparam int FIFO_DEPTH = 16;
   typedef enum logic [2:0] {
      M_PRE = 3'b000, M_HDR = 3'b001, M_TA = 3'b010, M_RD = 3'b011, M_WR = 3'b100
   } mdio_st_t;
   typedef enum logic [1:0] {G_IDLE = 2'b00, G_SEND = 2'b01, G_GAP = 2'b10} gen_st_t;
   typedef struct packed {
      logic last;
      logic [7:0] data;
   } tx_word_t;
endpackage

// File: rtl/phy_ext_page1_ctrl.sv
// Page-1 control/status registers, low-power timers, downshift and test packet generator.
// Assumes management clock/data arrive as raw pins; core status inputs are on core_clk.
`timescale 1ns/1ns

module tx_fifo #(
   parameter int W = 9,
   parameter int DEPTH = 16
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } fifo_st_t;
   fifo_st_t s_reg, s_next;
   logic push, pop;

   // Depth must be a power of two so pointers wrap naturally
   always_comb begin
      s_next = s_reg;
      push = in_valid && (s_reg.cnt != (AW+1)'(DEPTH));
      pop = (s_reg.cnt != '0) && out_ready;
      if (push) begin
         s_next.mem[s_reg.wp] = in_data;
         s_next.wp = s_reg.wp + 1'b1;
      end
      if (pop) s_next.rp = s_reg.rp + 1'b1;
      if (push && !pop) s_next.cnt = s_reg.cnt + 1'b1;
      else if (pop && !push) s_next.cnt = s_reg.cnt - 1'b1;
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) s_reg <= '0;
      else s_reg <= s_next;
   end

   assign in_ready = s_reg.cnt != (AW+1)'(DEPTH);
   assign out_valid = s_reg.cnt != '0;
   assign out_data = s_reg.mem[s_reg.rp];
endmodule // tx_fifo

module phy_ext_page1_ctrl #(
   parameter int unsigned MS_CYCLES = phy_ext_page1_pkg::MS_CYC,
   parameter int unsigned PKT_TOTAL = phy_ext_page1_pkg::PKT_TOTAL_DOC,
   parameter int unsigned PKT_BLOCK = phy_ext_page1_pkg::PKT_BLOCK_DOC
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic mdc,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe,
   input wire logic [4:0] phy_addr_strap,
   input wire logic energy_det,
   input wire logic media_copper,
   input wire logic an_fail_1g,
   input wire logic crc_err,
   input wire logic [1:0] pd_status,
   output logic carrier_ext_dis,
   output logic no_preamble_en,
   output logic slow_mdc,
   output logic pd_detect_en,
   output logic low_power,
   output logic wake_pulse,
   output logic downshift_req,
   output logic gen_active,
   output phy_ext_page1_pkg::tx_word_t tx_word,
   output logic tx_valid,
   input wire logic tx_ready
);
   import phy_ext_page1_pkg::*;
   localparam logic [15:0] BLOCKS = 16'(PKT_TOTAL / PKT_BLOCK);

   typedef struct packed {
      logic [1:0] mdc_sy;
      logic [1:0] mdio_sy;
      logic [1:0] strap_go;
      logic [4:0] strap_sy1;
      logic [4:0] strap_sy2;
      logic mdc_d;
      mdio_st_t ms;
      logic [5:0] ones;
      logic [4:0] bcnt;
      logic [15:0] sh;
      logic [4:0] radr;
      logic rd_op;
      logic [15:0] rdat;
      logic mdio_out;
      logic mdio_oe;
      logic [1:0] boot;
      logic [4:0] paddr;
      logic [15:0] sleep_ds;
      logic pd_en;
      logic [7:0] crc_cnt;
      logic [15:0] gen_ctl;
      logic [15:0] gen_pat;
      logic [2:0] fails;
      logic dshift;
      logic [17:0] ms_div;
      logic ms_tick;
      logic [11:0] ms_cnt;
      logic low_power;
      logic wake_pulse;
      gen_st_t gs;
      logic active;
      logic go_low;
      logic fin;
      logic done;
      logic [13:0] cfg;
      logic [15:0] pat;
      logic [13:0] idx;
      logic [13:0] len;
      logic [31:0] crc;
      logic [15:0] lfsr;
      logic [11:0] gap;
      logic [15:0] blk_pkt;
      logic [15:0] blocks;
      logic push_v;
      tx_word_t push_d;
   } st_t;

   st_t s_reg, s_next;
   logic rise, bit_in, rd_evt, wr_evt, go, adv, fifo_rdy, boundary;
   logic [12:0] hdr;
   logic [15:0] wdata, rd_mux;
   logic [11:0] sleep_ms, wake_ms, ipg;
   logic [2:0] ds_thr;
   logic [7:0] gbyte;

   function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c ^ {24'h000000, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   function automatic logic [13:0] frame_len(input logic [1:0] code);
      unique case (code)
         2'h0: frame_len = LEN0;
         2'h1: frame_len = LEN1;
         2'h2: frame_len = LEN2;
         2'h3: frame_len = LEN3;
      endcase
   endfunction

   always_comb begin
      s_next = s_reg;
      // Only the second stage of each synchroniser is looked at
      s_next.mdc_sy = {s_reg.mdc_sy[0], mdc};
      s_next.mdio_sy = {s_reg.mdio_sy[0], mdio_in};
      s_next.strap_sy1 = phy_addr_strap;
      s_next.strap_sy2 = s_reg.strap_sy1;
      s_next.mdc_d = s_reg.mdc_sy[1];
      rise = s_reg.mdc_sy[1] && !s_reg.mdc_d;
      bit_in = s_reg.mdio_sy[1];
      hdr = {s_reg.sh[11:0], bit_in};
      wdata = {s_reg.sh[14:0], bit_in};
      // Address strap is caught a few cycles after reset release
      if (s_reg.boot != 2'h3) begin
         s_next.boot = s_reg.boot + 2'h1;
         s_next.paddr = s_reg.strap_sy2;
      end

      // Read data for the addressed register
      rd_mux = 16'h0000;
      unique case (hdr[4:0])
         REG_SLEEP_DS: rd_mux = {s_reg.sleep_ds[15:10], 2'h0,
            media_copper ? MEDIA_COPPER : MEDIA_NONE, // [RULE5]
            s_reg.sleep_ds[5:2], s_reg.dshift, 1'b0}; // [RULE9]
         REG_PD_CRC: rd_mux = {s_reg.paddr, s_reg.pd_en, // [RULE10]
            s_reg.pd_en ? pd_status : 2'h0, s_reg.crc_cnt}; // [RULE11]
         REG_GEN_CTL: rd_mux = s_reg.gen_ctl;
         REG_GEN_PAT: rd_mux = s_reg.gen_pat;
         default: rd_mux = 16'h0000;
      endcase

      // Serial management frame slave
      rd_evt = 1'b0;
      wr_evt = 1'b0;
      if (rise) begin
         unique case (s_reg.ms)
            M_PRE: begin
               if (bit_in) begin
                  if (s_reg.ones != 6'(MDIO_PRE_BITS)) s_next.ones = s_reg.ones + 6'h01;
               end else begin
                  if (s_reg.ones == 6'(MDIO_PRE_BITS)) begin
                     s_next.ms = M_HDR;
                     s_next.bcnt = 5'h00;
                  end
                  s_next.ones = 6'h00;
               end
            end
            M_HDR: begin
               s_next.sh = {s_reg.sh[14:0], bit_in};
               s_next.bcnt = s_reg.bcnt + 5'h01;
               if (s_reg.bcnt == 5'd12) begin
                  s_next.bcnt = 5'h00;
                  s_next.radr = hdr[4:0];
                  s_next.rd_op = hdr[11:10] == OP_READ;
                  if (!hdr[12] || hdr[9:5] != s_reg.paddr ||
                      (hdr[11:10] != OP_READ && hdr[11:10] != OP_WRITE)) begin
                     s_next.ms = M_PRE;
                  end else begin
                     s_next.ms = M_TA;
                     rd_evt = hdr[11:10] == OP_READ;
                     s_next.rdat = rd_mux;
                  end
               end
            end
            M_TA: begin
               s_next.bcnt = s_reg.bcnt + 5'h01;
               if (s_reg.rd_op && s_reg.bcnt == 5'h00) begin
                  s_next.mdio_oe = 1'b1;
                  s_next.mdio_out = 1'b0;
               end
               if (s_reg.bcnt == 5'h01) begin
                  s_next.ms = s_reg.rd_op ? M_RD : M_WR;
                  s_next.bcnt = s_reg.rd_op ? 5'h01 : 5'h00;
                  if (s_reg.rd_op) s_next.mdio_out = s_reg.rdat[15];
               end
            end
            M_RD: begin
               if (s_reg.bcnt == 5'd16) begin
                  s_next.mdio_oe = 1'b0;
                  s_next.ms = M_PRE;
               end else begin
                  s_next.mdio_out = s_reg.rdat[4'(5'd15 - s_reg.bcnt)];
                  s_next.bcnt = s_reg.bcnt + 5'h01;
               end
            end
            M_WR: begin
               s_next.sh = {s_reg.sh[14:0], bit_in};
               s_next.bcnt = s_reg.bcnt + 5'h01;
               if (s_reg.bcnt == 5'd15) begin
                  wr_evt = 1'b1;
                  s_next.ms = M_PRE;
               end
            end
            default: s_next.ms = M_PRE;
         endcase
      end

      // Register writes; read-only fields are masked off
      if (wr_evt) begin
         unique case (s_reg.radr)
            REG_SLEEP_DS: s_next.sleep_ds = wdata & SLEEP_DS_WMASK;
            REG_PD_CRC: s_next.pd_en = wdata[PD_EN_BIT]; // [RULE10]
            REG_GEN_CTL: s_next.gen_ctl = wdata;
            REG_GEN_PAT: s_next.gen_pat = wdata;
            default: ;
         endcase
      end

      // Error count: read clears, but an error in the same cycle still counts
      if (rd_evt && hdr[4:0] == REG_PD_CRC) s_next.crc_cnt = {7'h00, crc_err}; // [RULE12]
      else if (crc_err && s_reg.crc_cnt != 8'hff) s_next.crc_cnt = s_reg.crc_cnt + 8'h01;

      // Downshift after enough failed gigabit negotiations
      ds_thr = 3'(s_reg.sleep_ds[DS_CNT_LSB +: 2]) + 3'h2; // [RULE8]
      if (!s_reg.sleep_ds[DS_EN_BIT]) begin
         s_next.fails = 3'h0;
         s_next.dshift = 1'b0; // [RULE7]
      end else begin
         if (an_fail_1g && s_reg.fails != 3'h7) s_next.fails = s_reg.fails + 3'h1;
         if (s_reg.fails >= ds_thr) s_next.dshift = 1'b1; // [RULE8]
      end

      // Millisecond enable and low-power sleep/wake timers
      s_next.ms_tick = 1'b0;
      s_next.ms_div = s_reg.ms_div + 18'h00001;
      if (s_reg.ms_div == 18'(MS_CYCLES - 1)) begin
         s_next.ms_div = 18'h00000;
         s_next.ms_tick = 1'b1;
      end
      sleep_ms = 12'(SLEEP_UNIT_MS * (int'(s_reg.sleep_ds[SLEEP_LSB +: 2]) + 1)); // [RULE2]
      unique case (s_reg.sleep_ds[WAKE_LSB +: 2]) // [RULE3]
         2'h0: wake_ms = WAKE_MS0;
         2'h1: wake_ms = WAKE_MS1;
         2'h2: wake_ms = WAKE_MS2;
         2'h3: wake_ms = WAKE_MS3;
      endcase
      s_next.wake_pulse = 1'b0;
      if (energy_det) begin
         s_next.low_power = 1'b0;
         s_next.ms_cnt = 12'h000;
      end else if (s_reg.ms_tick) begin
         s_next.ms_cnt = s_reg.ms_cnt + 12'h001;
         if (!s_reg.low_power && s_reg.ms_cnt + 12'h001 >= sleep_ms) begin
            s_next.low_power = 1'b1; // [RULE2]
            s_next.ms_cnt = 12'h000;
         end else if (s_reg.low_power && s_reg.ms_cnt + 12'h001 >= wake_ms) begin
            s_next.wake_pulse = 1'b1; // [RULE3]
            s_next.ms_cnt = 12'h000;
         end
      end

      // Test packet generator
      go = s_reg.gen_ctl[GEN_EN_BIT] && s_reg.gen_ctl[GEN_RUN_BIT]; // [RULE23]
      adv = !s_reg.push_v || fifo_rdy;
      ipg = s_reg.cfg[GEN_IPG_BIT] ? IPG_LONG_CYC : IPG_SHORT_CYC; // [RULE16]
      boundary = s_reg.blk_pkt == 16'(PKT_BLOCK - 1);
      if (!go) s_next.go_low = 1'b1;
      if (!go) s_next.fin = 1'b0;
      if (s_reg.push_v && fifo_rdy) s_next.push_v = 1'b0;
      if (s_reg.idx < 14'd5 || (s_reg.idx > 14'd5 && s_reg.idx < 14'd11)) gbyte = 8'hff;
      else if (s_reg.idx == 14'd5) gbyte = {4'hf, s_reg.cfg[GEN_DA_LSB +: 4]}; // [RULE17]
      else if (s_reg.idx == 14'd11) gbyte = {4'hf, s_reg.cfg[GEN_SA_LSB +: 4]}; // [RULE18]
      else if (s_reg.idx >= s_reg.len - FCS_BYTES)
         gbyte = ~s_reg.crc[7:0] ^ {8{s_reg.cfg[GEN_BADFCS_BIT]}}; // [RULE20]
      else if (s_reg.cfg[GEN_PAY_BIT])
         gbyte = s_reg.idx[0] ? s_reg.pat[7:0] : s_reg.pat[15:8]; // [RULE21]
      else gbyte = s_reg.lfsr[7:0]; // [RULE19]
      unique case (s_reg.gs)
         G_IDLE: begin
            if (go && !s_reg.fin) begin
               // Settings are frozen here, so later writes other than enable, run and the duration bit wait for a restart
               s_next.cfg = s_reg.gen_ctl[13:0]; // [RULE22]
               s_next.pat = s_reg.gen_pat; // [RULE22]
               s_next.len = frame_len(s_reg.gen_ctl[GEN_LEN_LSB +: 2]); // [RULE15]
               s_next.idx = 14'h0000;
               s_next.crc = CRC_INIT;
               s_next.blk_pkt = 16'h0000;
               s_next.blocks = 16'h0000;
               s_next.go_low = 1'b0;
               s_next.done = 1'b0;
               s_next.gs = G_SEND;
            end
         end
         G_SEND: begin
            if (adv) begin
               s_next.push_v = 1'b1;
               s_next.push_d = '{last: s_reg.idx == s_reg.len - 14'h0001, data: gbyte};
               s_next.idx = s_reg.idx + 14'h0001;
               if (s_reg.idx >= s_reg.len - FCS_BYTES) s_next.crc = s_reg.crc >> 8;
               else s_next.crc = crc_byte(s_reg.crc, gbyte);
               if (s_reg.idx >= HDR_BYTES && !s_reg.cfg[GEN_PAY_BIT])
                  s_next.lfsr = {s_reg.lfsr[14:0], s_reg.lfsr[15] ^ s_reg.lfsr[13] ^
                     s_reg.lfsr[12] ^ s_reg.lfsr[10]};
               if (s_reg.idx == s_reg.len - 14'h0001) begin
                  s_next.gs = G_GAP;
                  s_next.gap = ipg - 12'h001; // [RULE16]
                  s_next.blk_pkt = boundary ? 16'h0000 : s_reg.blk_pkt + 16'h0001;
                  if (boundary) s_next.blocks = s_reg.blocks + 16'h0001;
                  s_next.done = boundary && ((s_reg.cfg[GEN_DUR_BIT] &&
                     !s_reg.gen_ctl[GEN_DUR_BIT]) || // [RULE14]
                     (!s_reg.cfg[GEN_DUR_BIT] && s_reg.blocks == BLOCKS - 16'h0001));
               end
            end
         end
         G_GAP: begin
            s_next.gap = s_reg.gap - 12'h001;
            if (s_reg.gap == 12'h000) begin
               s_next.idx = 14'h0000;
               s_next.crc = CRC_INIT;
               s_next.gs = G_SEND;
               // A frame in flight is finished; a dropped run bit halts here
               if (s_reg.done || s_reg.go_low || !go) begin // [RULE23]
                  s_next.gs = G_IDLE;
                  s_next.fin = s_reg.done && go;
               end
            end
         end
         default: s_next.gs = G_IDLE;
      endcase
      s_next.active = s_next.gs != G_IDLE;
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s_reg <= '0;
         s_reg.sleep_ds <= SLEEP_DS_RST;
         s_reg.gen_ctl <= GEN_CTL_RST;
         s_reg.gen_pat <= GEN_PAT_RST;
         s_reg.lfsr <= LFSR_SEED;
         s_reg.ms <= M_PRE;
         s_reg.gs <= G_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   tx_fifo #(.W($bits(tx_word_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
      .core_clk(core_clk),
      .nrst(nrst),
      .in_valid(s_reg.push_v),
      .in_data(s_reg.push_d),
      .in_ready(fifo_rdy),
      .out_valid(tx_valid),
      .out_data(tx_word),
      .out_ready(tx_ready)
   );

   assign mdio_out = s_reg.mdio_out;
   assign mdio_oe = s_reg.mdio_oe;
   assign carrier_ext_dis = s_reg.sleep_ds[CE_DIS_BIT]; // [RULE1]
   assign no_preamble_en = s_reg.sleep_ds[NOPRE_BIT]; // [RULE6]
   assign slow_mdc = s_reg.sleep_ds[SLOW_MDC_BIT];
   assign pd_detect_en = s_reg.pd_en;
   assign low_power = s_reg.low_power;
   assign wake_pulse = s_reg.wake_pulse;
   assign downshift_req = s_reg.dshift;
   assign gen_active = s_reg.active;

   sequence seq_reg_write(logic [4:0] a);
      wr_evt && s_reg.radr == a;
   endsequence
   sequence seq_crc_read;
      rd_evt && hdr[4:0] == REG_PD_CRC && !crc_err;
   endsequence

   chk_ce_write: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE1]
      seq_reg_write(REG_SLEEP_DS) |=> carrier_ext_dis == $past(wdata[CE_DIS_BIT]))
      else $error("carrier extension bit not taken from write");
   chk_sleep_delay: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE2]
      $rose(low_power) |-> $past(s_reg.ms_cnt) == $past(sleep_ms) - 12'h001)
      else $error("sleep entered at wrong delay");
   chk_wake_interval: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE3]
      wake_pulse |-> $past(low_power) && $past(s_reg.ms_cnt) == $past(wake_ms) - 12'h001)
      else $error("wake pulse at wrong interval");
   chk_media_read: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE5]
      (rd_evt && hdr[4:0] == REG_SLEEP_DS) |=>
      s_reg.rdat[7:6] == ($past(media_copper) ? MEDIA_COPPER : MEDIA_NONE))
      else $error("media status readback wrong");
   chk_ds_off: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE7]
      !s_reg.sleep_ds[DS_EN_BIT] |=> !downshift_req)
      else $error("downshift while disabled");
   chk_ds_count: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE8]
      $rose(downshift_req) |-> $past(s_reg.fails) >= $past(ds_thr))
      else $error("downshift before attempt count reached");
   chk_addr_ro: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE10]
      seq_reg_write(REG_PD_CRC) |=> $stable(s_reg.paddr))
      else $error("address field changed by write");
   chk_crc_clear: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE12]
      seq_crc_read |=> s_reg.crc_cnt == 8'h00)
      else $error("error count not cleared by read");
   chk_cfg_frozen: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE22]
      (s_reg.gs != G_IDLE && $past(s_reg.gs) != G_IDLE) |-> $stable(s_reg.cfg))
      else $error("settings changed during a run");
   chk_gen_halt: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE23]
      (s_reg.gs == G_IDLE && !go) |=> s_reg.gs == G_IDLE)
      else $error("generator started without enable and run");
   chk_gap_load: assert property (@(posedge core_clk) disable iff (!nrst) // [RULE16]
      (s_reg.gs == G_SEND && s_next.gs == G_GAP) |=> s_reg.gap == $past(ipg) - 12'h001)
      else $error("wrong gap length loaded");
endmodule // phy_ext_page1_ctrl

// File: tb/mdio_master.sv
// Station manager model driving the management clock and data line.
// Assumes the line has a pull-up and the device samples on mdc rises.
`timescale 1ns/1ns
module mdio_master (
   input wire logic core_clk,
   input wire logic dev_out,
   input wire logic dev_oe,
   output logic mdc,
   output logic mdio
);
   logic m_oe = 1'b0;
   logic m_d = 1'b1;
   // Pull-up wins when nobody drives
   assign mdio = dev_oe ? dev_out : (m_oe ? m_d : 1'b1);
   initial mdc = 1'b0;
   // 17-cycle mdc period keeps well above the 3-cycle minimum level
   task automatic xfer(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
         output logic [15:0] rd);
      logic [63:0] v;
      v = {32'hffffffff, 2'b01, op, 5'h03, ra, 2'b10, wd};
      for (int i = 63; i >= 0; i--) begin
         @(negedge core_clk);
         mdc = 1'b0;
         m_oe = (op == 2'h1) || (i > 17);
         m_d = v[i];
         repeat (8) @(negedge core_clk);
         mdc = 1'b1;
         if (i < 16) rd[i] = mdio;
         repeat (8) @(negedge core_clk);
      end
      mdc = 1'b0;
      m_oe = 1'b0;
   endtask
endmodule // mdio_master

// File: tb/testbench.sv
// Self-checking bench for the page-1 register group and packet generator.
// Assumes strap address 3, shortened ms and packet-count parameters.
`timescale 1ns/1ns
module testbench;
   import phy_ext_page1_pkg::*;
   logic core_clk = 0, nrst = 0, energy_det = 1, media_copper = 0, an_fail_1g = 0;
   logic crc_err = 0, tx_ready = 0, mdc, mdio, mdio_out, mdio_oe, carrier_ext_dis;
   logic no_preamble_en, slow_mdc, pd_detect_en, low_power, downshift_req, gen_active;
   logic tx_valid, wake_pulse;
   logic [1:0] pd_status = 0;
   logic [15:0] rd;
   tx_word_t tx_word;
   int n_fail = 0, samples_checked = 0, n_last = 0, n_wake = 0;
   always #2 core_clk = ~core_clk;
   // Frames delivered and wake pulses seen, sampled away from the launching edge
   always @(negedge core_clk) begin
      if (tx_valid && tx_ready && tx_word.last) n_last++;
      if (wake_pulse) n_wake++;
   end
   phy_ext_page1_ctrl #(.MS_CYCLES(10), .PKT_TOTAL(20), .PKT_BLOCK(5)) u_phy_ext_page1_ctrl (
      .core_clk, .nrst, .mdc, .mdio_in(mdio), .mdio_out, .mdio_oe, .phy_addr_strap(5'h03),
      .energy_det, .media_copper, .an_fail_1g, .crc_err, .pd_status, .carrier_ext_dis,
      .no_preamble_en, .slow_mdc, .pd_detect_en, .low_power, .wake_pulse, .downshift_req,
      .gen_active, .tx_word, .tx_valid, .tx_ready);
   mdio_master u_mdio_master (.core_clk, .dev_out(mdio_out), .dev_oe(mdio_oe), .mdc, .mdio);
   task chk(input logic [15:0] s, input logic [15:0] e);
      samples_checked++;
      if (s !== e) begin
         n_fail++;
         $display("Error t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task wr(input logic [4:0] ra, input logic [15:0] wd);
      u_mdio_master.xfer(OP_WRITE, ra, wd, rd);
   endtask
   task rdc(input logic [4:0] ra, input logic [15:0] e);
      u_mdio_master.xfer(OP_READ, ra, 16'h0000, rd);
      chk(rd, e);
   endtask
   task final_report;
      $display("checked %0d failed %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task t_reset;
      chk(carrier_ext_dis, 1'b1);
      rdc(REG_SLEEP_DS, 16'ha004);
      rdc(REG_GEN_CTL, 16'h0040);
      rdc(REG_GEN_PAT, 16'h0000);
      rdc(5'h15, 16'h0000);
   endtask
   task t_ctl3;
      media_copper = 1;
      wr(REG_SLEEP_DS, 16'hffff);
      rdc(REG_SLEEP_DS, 16'hfc7c);
      chk({slow_mdc, no_preamble_en}, 2'h3);
      for (int i = 0; i < 5; i++) begin
         chk(downshift_req, 1'b0);
         @(negedge core_clk) an_fail_1g = 1;
         @(negedge core_clk) an_fail_1g = 0;
         repeat (4) @(negedge core_clk);
      end
      chk(downshift_req, 1'b1);
      wr(REG_SLEEP_DS, 16'h2000);
      chk(downshift_req, 1'b0);
   endtask
   task t_ctl4;
      wr(REG_PD_CRC, 16'hffff);
      pd_status = 2'h2;
      repeat (3) begin
         @(negedge core_clk) crc_err = 1;
         @(negedge core_clk) crc_err = 0;
      end
      rdc(REG_PD_CRC, {5'h03, 3'h6, 8'h03});
      rdc(REG_PD_CRC, {5'h03, 3'h6, 8'h00});
   endtask
   task t_gen;
      int n;
      logic [7:0] e;
      logic [9:0] w;
      wr(REG_GEN_PAT, 16'h5aa5);
      wr(REG_GEN_CTL, 16'hc94e);
      // Stalled sink must leave the head word waiting, not dropped
      repeat (60) @(negedge core_clk);
      chk({gen_active, tx_valid}, 2'h3);
      tx_ready = 1;
      for (int f = 0; f < 20; f++) for (int i = 0; i < 64; i++) begin
         n = 0;
         while (tx_valid !== 1'b1 && n < 5000) begin
            @(negedge core_clk);
            n++;
         end
         e = i < 12 ? (i == 5 ? 8'hf5 : i == 11 ? 8'hf3 : 8'hff) : i[0] ? 8'ha5 : 8'h5a;
         w = {tx_valid, tx_word.last, i < 60 ? tx_word.data : 8'h00};
         chk(w, {1'b1, i == 63, i < 60 ? e : 8'h00});
         // Head word is taken at the next rising edge
         @(negedge core_clk);
      end
      repeat (300) @(negedge core_clk);
      chk({gen_active, tx_valid}, 2'h0);
      chk(n_last, 16'h0014);
      wr(REG_GEN_CTL, 16'h0000);
   endtask
   task t_cont;
      // Continuous run; clearing the mode mid-run ends at the next block of five
      wr(REG_GEN_CTL, 16'he94e);
      wr(REG_GEN_CTL, 16'hc94e);
      repeat (600) @(negedge core_clk);
      chk(n_last, 16'h0023);
      chk({gen_active, tx_valid}, 2'h0);
   endtask
   task t_sleep;
      energy_det = 0;
      repeat (19000) @(negedge core_clk);
      chk(low_power, 1'b0);
      repeat (2000) @(negedge core_clk);
      chk(low_power, 1'b1);
      chk(n_wake, 16'h0000);
      repeat (1700) @(negedge core_clk);
      chk(n_wake, 16'h0001);
      energy_det = 1;
      repeat (2) @(negedge core_clk);
      chk(low_power, 1'b0);
   endtask
   initial begin
      repeat (5) @(negedge core_clk);
      nrst = 1;
      repeat (6) @(negedge core_clk);
      t_reset;
      t_ctl3;
      t_ctl4;
      t_gen;
      t_cont;
      t_sleep;
      final_report;
   end
   initial begin
      #300000;
      n_fail++;
      final_report;
   end
endmodule // testbench
